// [rtl/fbd_top.sv]
// Filament full-bridge drive generator with its register file
//
// Added by the designer: strobed register access.
`default_nettype none
module fbd_top
	import fbd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata_ff,
	// Display state
	input  wire logic       blink_phase_one,
	// Bridge driver pins
	output var  logic       filament_phase_a_out,
	output var  logic       filament_phase_b_out
);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	fbd_bus_req_type req;
	logic [7:0]      on_count_ff;
	fbd_sel_type     sel_a_ff;
	fbd_sel_type     sel_b_ff;
	logic            shutdown_ff;
	logic [7:0]      nxt_rdata;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			on_count_ff <= FBD_ON_COUNT_RST;
		end else if (req.wr && req.addr == FBD_ADDR_ON_COUNT) begin
			on_count_ff <= req.wdata;
		end
	end

	// Upper select bits are not stored, so they read back as zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_a_ff <= fbd_sel_type'(FBD_SEL_RST);
			sel_b_ff <= fbd_sel_type'(FBD_SEL_RST);
		end else if (req.wr) begin
			if (req.addr == FBD_ADDR_SEL_A) begin
				sel_a_ff <= fbd_sel_type'(req.wdata[1:0]);
			end
			if (req.addr == FBD_ADDR_SEL_B) begin
				sel_b_ff <= fbd_sel_type'(req.wdata[1:0]);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shutdown_ff <= FBD_SHDN_RST;
		end else if (req.wr && req.addr == FBD_ADDR_CTRL) begin
			shutdown_ff <= req.wdata[FBD_CTRL_SHDN_BIT];
		end
	end

	// ------------------------------------------------------------
	// Oscillator tick
	// ------------------------------------------------------------
	logic [2:0] div_ff;
	logic       osc_tick;

	assign osc_tick = (div_ff == FBD_OSC_DIV_LAST);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff <= 3'h0;
		end else if (osc_tick) begin
			div_ff <= 3'h0;
		end else begin
			div_ff <= div_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	logic [8:0]  pos_ff;
	logic [7:0]  frame_on_ff;
	logic [7:0]  on_clamped;
	fbd_seg_type seg_ff;
	fbd_seg_type nxt_seg;
	logic [8:0]  nxt_pos;
	logic [8:0]  drive_one_start;
	logic [8:0]  drive_two_start;
	logic [8:0]  drive_two_end;

	// Out-of-range values are clamped so both drive pulses fit in the 400-tick frame
	always_comb begin
		if (on_count_ff < FBD_ON_COUNT_MIN) begin
			on_clamped = FBD_ON_COUNT_MIN;
		end else if (on_count_ff > FBD_ON_COUNT_MAX) begin
			on_clamped = FBD_ON_COUNT_MAX;
		end else begin
			on_clamped = on_count_ff;
		end
	end

	assign nxt_pos = (pos_ff == FBD_FRAME_LAST) ? 9'h000 : pos_ff + 9'h001;

	// Count is taken only at frame start to keep the two polarities equal
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_on_ff <= FBD_ON_COUNT_RST;
		end else if (osc_tick && nxt_pos == 9'h000) begin
			frame_on_ff <= on_clamped;
		end
	end

	// Shutdown parks the sequencer so the next frame starts clean
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_ff <= FBD_FRAME_LAST;
		end else if (shutdown_ff) begin
			pos_ff <= FBD_FRAME_LAST;
		end else if (osc_tick) begin
			pos_ff <= nxt_pos;
		end
	end

	assign drive_one_start = FBD_HALF_POINT - {1'b0, frame_on_ff};
	assign drive_two_start = FBD_HALF_POINT + FBD_GAP_CYCLES;
	assign drive_two_end   = drive_two_start + {1'b0, frame_on_ff};

	// Segment of the current position; a zero-length idle is skipped
	always_comb begin
		if (pos_ff < drive_one_start) begin
			nxt_seg = FBD_SEG_IDLE_LEAD;
		end else if (pos_ff < FBD_HALF_POINT) begin
			nxt_seg = FBD_SEG_DRIVE_ONE;
		end else if (pos_ff < drive_two_start) begin
			nxt_seg = FBD_SEG_GAP;
		end else if (pos_ff < drive_two_end) begin
			nxt_seg = FBD_SEG_DRIVE_TWO;
		end else begin
			nxt_seg = FBD_SEG_IDLE_TRAIL;
		end
		if (shutdown_ff) begin
			nxt_seg = FBD_SEG_IDLE_LEAD;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seg_ff <= FBD_SEG_IDLE_LEAD;
		end else begin
			seg_ff <= nxt_seg;
		end
	end

	// ------------------------------------------------------------
	// Waveforms and pins
	// ------------------------------------------------------------
	logic wave_a;
	logic wave_b;

	always_comb begin
		case (seg_ff)
			FBD_SEG_DRIVE_ONE: begin
				wave_a = 1'b0;
				wave_b = 1'b1;
			end
			FBD_SEG_DRIVE_TWO: begin
				wave_a = 1'b1;
				wave_b = 1'b0;
			end
			default: begin
				wave_a = 1'b0;
				wave_b = 1'b0;
			end
		endcase
	end

	fbd_pin_select u_pin_a (
		.clk             (clk),
		.rst_b           (rst_b),
		.sel             (sel_a_ff),
		.shutdown        (shutdown_ff),
		.blink_phase_one (blink_phase_one),
		.wave            (wave_a),
		.pin_ff          (filament_phase_a_out)
	);

	fbd_pin_select u_pin_b (
		.clk             (clk),
		.rst_b           (rst_b),
		.sel             (sel_b_ff),
		.shutdown        (shutdown_ff),
		.blink_phase_one (blink_phase_one),
		.wave            (wave_b),
		.pin_ff          (filament_phase_b_out)
	);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		case (req.addr)
			FBD_ADDR_ON_COUNT: nxt_rdata = on_count_ff;
			FBD_ADDR_SEL_A:    nxt_rdata = {6'h00, sel_a_ff};
			FBD_ADDR_SEL_B:    nxt_rdata = {6'h00, sel_b_ff};
			FBD_ADDR_CTRL:     nxt_rdata = {7'h00, shutdown_ff};
			FBD_ADDR_STATUS:   nxt_rdata = {5'h00, seg_ff};
			default:           nxt_rdata = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

endmodule // fbd_top
`default_nettype wire

// [include/fbd_pkg.sv]
// Constants and types shared by the filament bridge drive block
`default_nettype none
package fbd_pkg;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] FBD_ADDR_CTRL      = 8'h20;
	localparam logic [7:0] FBD_ADDR_STATUS    = 8'h21;
	localparam logic [7:0] FBD_ADDR_ON_COUNT  = 8'h09;
	localparam logic [7:0] FBD_ADDR_SEL_A     = 8'h0a;
	localparam logic [7:0] FBD_ADDR_SEL_B     = 8'h0b;
	localparam int         FBD_CTRL_SHDN_BIT  = 0;
	localparam logic [7:0] FBD_ON_COUNT_RST   = 8'h01;
	localparam logic [7:0] FBD_ON_COUNT_MIN   = 8'h01;
	localparam logic [7:0] FBD_ON_COUNT_MAX   = 8'hc7;
	localparam logic [1:0] FBD_SEL_RST        = 2'h0;
	localparam logic       FBD_SHDN_RST       = 1'b0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         FBD_CLK_PERIOD_NS  = 50;
	localparam int         FBD_OSC_PERIOD_NS  = 250;
	localparam int         FBD_OSC_DIV        =
		FBD_OSC_PERIOD_NS / FBD_CLK_PERIOD_NS;
	localparam logic [2:0] FBD_OSC_DIV_LAST   = 3'(FBD_OSC_DIV - 1);
	localparam logic [8:0] FBD_FRAME_LAST     = 9'h18f;
	localparam logic [8:0] FBD_HALF_POINT     = 9'h0c7;
	localparam logic [8:0] FBD_GAP_CYCLES     = 9'h002;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FBD_SEL_LOW   = 2'b00,
		FBD_SEL_HIGH  = 2'b01,
		FBD_SEL_BLINK = 2'b10,
		FBD_SEL_WAVE  = 2'b11
	} fbd_sel_type;

	typedef enum logic [2:0] {
		FBD_SEG_IDLE_LEAD  = 3'b000,
		FBD_SEG_DRIVE_ONE  = 3'b001,
		FBD_SEG_GAP        = 3'b010,
		FBD_SEG_DRIVE_TWO  = 3'b011,
		FBD_SEG_IDLE_TRAIL = 3'b100
	} fbd_seg_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fbd_bus_req_type;

endpackage
`default_nettype wire

// [rtl/fbd_pin_select.sv]
// Output function selector for one filament phase pin
`default_nettype none
module fbd_pin_select
	import fbd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Control
	input  wire fbd_sel_type sel,
	input  wire logic        shutdown,
	input  wire logic        blink_phase_one,
	input  wire logic        wave,
	// Pin
	output var  logic        pin_ff
);

	logic nxt_pin;

	always_comb begin
		case (sel)
			FBD_SEL_LOW:   nxt_pin = 1'b0;
			FBD_SEL_HIGH:  nxt_pin = 1'b1;
			FBD_SEL_BLINK: nxt_pin = blink_phase_one;
			FBD_SEL_WAVE:  nxt_pin = wave & ~shutdown;
			default:       nxt_pin = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_ff <= 1'b0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end

endmodule // fbd_pin_select
`default_nettype wire

// [bench/fbd_top_monitor.sv]
// Port checker for the filament bridge drive
`default_nettype none
module fbd_top_monitor
	import fbd_pkg::*;
(
	// Clock, reset and register port
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata_ff,
	// Pins
	input wire logic       blink_phase_one,
	input wire logic       filament_phase_a_out,
	input wire logic       filament_phase_b_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic pa = filament_phase_a_out;
	wire logic pb = filament_phase_b_out;
	wire logic wa = wr && addr == FBD_ADDR_SEL_A;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_excl; !(pa && pb); endproperty
	a_excl: assert property (p_excl) else $error("legs overlap");
	property p_idle; !rd |=> rdata_ff == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data");
	property p_selrd; rd && addr[7:1] == 7'h05 |=> rdata_ff[7:2] == 6'h00;
	endproperty
	a_selrd: assert property (p_selrd) else $error("select bits");
	property p_gap; $fell(pb) |=> !pa [*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_min; $rose(pb) |-> pb [*5]; endproperty
	a_min: assert property (p_min) else $error("short pulse");
	property p_shdn; wr && addr == FBD_ADDR_CTRL && wdata[0] |-> ##3 !pa [*8];
	endproperty
	a_shdn: assert property (p_shdn) else $error("shutdown");
	property p_hi; wa && wdata[1:0] == 2'b01 |-> ##3 pa; endproperty
	a_hi: assert property (p_hi) else $error("static high");
	property p_lo; wa && wdata[1:0] == 2'b00 |-> ##3 !pa; endproperty
	a_lo: assert property (p_lo) else $error("static low");
	property p_blk; wa && wdata[1:0] == 2'b10 |-> ##3 pa == blink_phase_one;
	endproperty
	a_blk: assert property (p_blk) else $error("blink");
	property p_blo;
		wr && addr == FBD_ADDR_SEL_B && wdata[1:0] == 2'b00 |-> ##3 !pb;
	endproperty
	a_blo: assert property (p_blo) else $error("phase b low");
endmodule // fbd_top_monitor
bind fbd_top fbd_top_monitor fbd_top_monitor_i (.clk(clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
	.blink_phase_one(blink_phase_one),
	.filament_phase_a_out(filament_phase_a_out),
	.filament_phase_b_out(filament_phase_b_out));
`default_nettype wire

// [bench/fbd_bridge_model.sv]
// Bridge transistor pair that latches a shoot-through fault
`default_nettype none
module fbd_bridge_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Gate drives
	input  wire logic gate_a,
	input  wire logic gate_b,
	// Fault
	output var  logic shoot_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	// Both legs on shorts the supply, so the fault sticks until reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			shoot_ff <= 1'b0;
		else if (gate_a && gate_b)
			shoot_ff <= 1'b1;
	end
endmodule // fbd_bridge_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the filament bridge drive
`default_nettype none
module tb
	import fbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, blink = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_ff;
	logic       pa, pb, shoot_ff, s;
	int         err_count = 0, check_count = 0;
	always #25 clk = ~clk;
	fbd_top fbd_top_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_ff(rdata_ff), .blink_phase_one(blink),
		.filament_phase_a_out(pa), .filament_phase_b_out(pb));
	fbd_bridge_model fbd_bridge_model_i (.clk(clk), .rst_b(rst_b),
		.gate_a(pa), .gate_b(pb), .shoot_ff(shoot_ff));
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(16'(rdata_ff), 16'(e));
	endtask
	// Select reg then pin: allow the two-clock lag to settle
	task automatic pins(input logic [1:0] e);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(16'({pa, pb}), 16'(e));
	endtask
	// Indexes run from the rising edge of phase b; nv is written mid-pulse
	task automatic frame(input int n, input logic [7:0] nv);
		logic [15:0] fb, fa, ea;
		logic [1:0]  per;
		int          w;
		fb = 16'h0000;
		fa = 16'h0000;
		ea = 16'h0000;
		w = 0;
		while (pb !== 1'b0 && w < 2100) begin
			@(negedge clk);
			w++;
		end
		while (pb !== 1'b1 && w < 4200) begin
			@(negedge clk);
			w++;
		end
		for (int i = 1; i <= 2000; i++) begin
			@(posedge clk);
			wr <= (i == 2 && nv != 8'h00);
			addr <= FBD_ADDR_ON_COUNT;
			wdata <= nv;
			@(negedge clk);
			if (pb !== 1'b1 && fb == 0) fb = 16'(i);
			if (pa === 1'b1 && fa == 0) fa = 16'(i);
			if (pa !== 1'b1 && fa != 0 && ea == 0) ea = 16'(i);
			per = {per[0], pb};
		end
		check(fb, 16'(5 * n));
		check(fa, 16'(5 * n + 10));
		check(ea, 16'(10 * n + 10));
		if (nv == 8'h00) check(16'(per), 16'h0001);
	endtask
	initial begin
		#3_000_000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(FBD_ADDR_ON_COUNT, 8'h01);
		rd_reg(FBD_ADDR_SEL_A, 8'h00);
		rd_reg(FBD_ADDR_SEL_B, 8'h00);
		rd_reg(8'hff, 8'h00);
		pins(2'b00);
		wr_reg(FBD_ADDR_SEL_A, 8'hfd);
		rd_reg(FBD_ADDR_SEL_A, 8'h01);
		pins(2'b10);
		@(posedge clk);
		blink <= 1'b1;
		wr_reg(FBD_ADDR_SEL_A, 8'h02);
		pins(2'b10);
		@(posedge clk);
		blink <= 1'b0;
		pins(2'b00);
		@(posedge clk);
		blink <= 1'b1;
		wr_reg(FBD_ADDR_SEL_A, 8'h00);
		pins(2'b00);
		@(posedge clk);
		blink <= 1'b0;
		wr_reg(FBD_ADDR_ON_COUNT, 8'h03);
		wr_reg(FBD_ADDR_SEL_A, 8'h03);
		wr_reg(FBD_ADDR_SEL_B, 8'h03);
		repeat (2000) @(posedge clk);
		frame(3, 8'h00);
		frame(3, 8'hc7);
		frame(199, 8'h00);
		rd_reg(FBD_ADDR_ON_COUNT, 8'hc7);
		wr_reg(FBD_ADDR_SEL_B, 8'h00);
		wr_reg(FBD_ADDR_CTRL, 8'h01);
		s = 1'b0;
		repeat (2000) @(negedge clk) s = s | pa;
		check(16'(s), 16'h0000);
		rd_reg(FBD_ADDR_CTRL, 8'h01);
		rd_reg(FBD_ADDR_STATUS, 8'h00);
		wr_reg(FBD_ADDR_SEL_B, 8'h01);
		pins(2'b01);
		wr_reg(FBD_ADDR_SEL_B, 8'h03);
		pins(2'b00);
		check(16'(shoot_ff), 16'h0000);
		complete_run();
	end
endmodule // tb
`default_nettype wire
